/* rtl/data_move_instr_exec.sv */
`timescale 1ns/10ps
// Functional notes
// - file move sends value to W or file
// - access bit zero uses access bank
// - access bit one uses bank register
// - extended set low offsets use indexed mode
// - two-word move decoded from 1100/1111 words
// - W may be source or destination
// - first cycle reads source, no write
// - second cycle writes destination; skipped takes two
module data_move_instr_exec
    import data_move_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // instruction fetch path, word valid in phase one
    input  wire logic [15:0] instr,
    input  wire logic        instr_valid,
    input  wire logic        skip,
    // core state
    input  wire logic [3:0]  bank_selection_register,
    input  wire logic [11:0] index_base,
    input  wire logic        ext_set_en,
    // data memory
    output logic      [11:0] mem_addr,
    output logic             mem_rd,
    input  wire logic [7:0]  mem_rdata,
    output logic             mem_wr,
    output logic      [7:0]  mem_wdata,
    // working register and flags
    output logic      [7:0]  wreg,
    output logic             flag_n,
    output logic             flag_z,
    output logic             flag_we,
    // status
    output logic             busy,
    output logic             illegal_dest
);

    // ==========================================================
    // declarations
    // ==========================================================
    logic [1:0]  phase;                        // q1..q4 as 0..3
    ff_state_t   state;                        // two-word sequencer
    logic [15:0] cur;                          // instruction latched at q1
    logic        cur_skip;                     // latched skip for this cycle
    logic [11:0] src_addr;                     // two-word source address
    logic [7:0]  data;                         // value read in q2
    logic        is_move;                      // single-word move decoded
    logic        is_ff1;                       // two-word first word decoded
    logic        is_ff2;                       // second word in ff state
    logic [11:0] next_addr;                    // resolved address

    // resolve the 8-bit file field into the 12-bit data space
    function automatic logic [11:0] resolve(input logic [15:0] w, input logic [3:0] bank,
                                            input logic ext, input logic [11:0] base);
        logic [7:0] f;
        f = w[7:0];
        if (w[POS_ACCESS_BIT])
            resolve = {bank, f};
        else if (ext && f <= INDEXED_LIMIT)
            resolve = 12'(base + {4'h0, f});
        else if (f < ACCESS_SPLIT)
            resolve = {4'h0, f};
        else
            resolve = {ACCESS_HIGH_BANK, f};
    endfunction

    // ==========================================================
    // decode
    // ==========================================================
    // second word is only meaningful while the sequencer waits for it
    always_comb begin
        is_ff2  = (state == ST_FF_SECOND) && cur[15:12] == OPC_FF_SECOND;
        is_move = (state == ST_IDLE) && cur[15:10] == OPC_MOVE_FILE_TO_DEST;
        is_ff1  = (state == ST_IDLE) && cur[15:12] == OPC_FF_FIRST;
        if (is_ff1)
            next_addr = cur[11:0];
        else if (is_ff2)
            next_addr = cur[11:0];
        else
            next_addr = resolve(cur, bank_selection_register, ext_set_en, index_base);
    end

    // ==========================================================
    // phase counter
    // ==========================================================
    // free-running four-phase divider of the instruction clock
    // no enable: the divider keeps turning through skipped and invalid slots
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            phase <= RESET_PHASE;
        else
            phase <= phase + 2'h1;
    end

    // ==========================================================
    // instruction latch
    // ==========================================================
    // captured at q1 so the word stays stable across the cycle
    // an invalid fetch latches as all zeros, which decodes as no move
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur      <= 16'h0000;
            cur_skip <= 1'b0;
        end else if (phase == 2'h0) begin
            cur      <= instr_valid ? instr : 16'h0000;
            cur_skip <= skip;
        end
    end

    // ==========================================================
    // two-word sequencer
    // ==========================================================
    // a skipped first word leaves the sequencer idle, so the 1111 word behind
    // it decodes as nothing and runs as a nop: two cycles in all;
    // arming on a skipped word would let that second word write stale data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state    <= ST_IDLE;
            src_addr <= 12'h000;
        end else if (phase == 2'h3) begin
            case (state)
                ST_IDLE: begin
                    if (is_ff1 && !cur_skip) begin
                        state    <= ST_FF_SECOND;
                        src_addr <= cur[11:0];
                    end
                end
                ST_FF_SECOND: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // data memory read in q2
    // ==========================================================
    // w is served from the core register, not memory
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            data <= 8'h00;
        end else if (phase == 2'h1 && !cur_skip && (is_move || is_ff1)) begin
            if (next_addr == ADDR_WREG)
                data <= wreg;
            else
                data <= mem_rdata;
        end
    end

    // bus strobes: read only in q2 of a first cycle, none in the second
    always_comb begin
        mem_addr = next_addr;
        mem_rd   = (phase == 2'h1) && !cur_skip && (is_move || is_ff1) && next_addr != ADDR_WREG;
    end

    // destination guard; software must keep these out
    always_comb begin
        illegal_dest = is_ff2 && (cur[11:0] == ADDR_PC_LOW || cur[11:0] == ADDR_STACK_TOP_LOW ||
                       cur[11:0] == ADDR_STACK_TOP_HIGH || cur[11:0] == ADDR_STACK_TOP_UPPER);
        busy         = (state == ST_FF_SECOND);
    end

    // ==========================================================
    // q4 write back
    // ==========================================================
    // memory write: single move with d set, or second word of two-word move
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_wr    <= 1'b0;
            mem_wdata <= 8'h00;
        end else begin
            mem_wr <= 1'b0;
            if (phase == 2'h2 && !cur_skip) begin
                if (is_move && cur[POS_DEST_BIT] && next_addr != ADDR_WREG) begin
                    mem_wr    <= 1'b1;
                    mem_wdata <= data;
                end else if (is_ff2 && !illegal_dest && cur[11:0] != ADDR_WREG) begin
                    mem_wr    <= 1'b1;
                    mem_wdata <= data;
                end
            end
        end
    end

    // working register: d clear, or a w target of either move
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wreg <= RESET_WREG;
        end else if (phase == 2'h3 && !cur_skip) begin
            if (is_move && (!cur[POS_DEST_BIT] || next_addr == ADDR_WREG))
                wreg <= data;
            else if (is_ff2 && cur[11:0] == ADDR_WREG)
                wreg <= data;
        end
    end

    // flags follow only the single-word move
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_n  <= 1'b0;
            flag_z  <= 1'b0;
            flag_we <= 1'b0;
        end else begin
            flag_we <= 1'b0;
            if (phase == 2'h3 && !cur_skip && is_move) begin
                flag_n  <= data[7];
                flag_z  <= (data == 8'h00);
                flag_we <= 1'b1;
            end
        end
    end

endmodule

/* rtl/data_move_pkg.sv */
// ==========================================================
// shared constants for the data move decode/execute block
// ==========================================================
package data_move_pkg;

    // ==========================================================
    // opcode fields
    // ==========================================================
    localparam logic [5:0]  OPC_MOVE_FILE_TO_DEST = 6'h14;        // upper bits 0101 00
    localparam logic [3:0]  OPC_FF_FIRST          = 4'hC;         // prefix 1100
    localparam logic [3:0]  OPC_FF_SECOND         = 4'hF;         // prefix 1111
    localparam int          POS_DEST_BIT          = 9;            // d bit position
    localparam int          POS_ACCESS_BIT        = 8;            // a bit position

    // ==========================================================
    // addressing constants
    // ==========================================================
    localparam logic [7:0]  INDEXED_LIMIT         = 8'h5F;        // highest indexed offset, 95
    localparam logic [7:0]  ACCESS_SPLIT          = 8'h60;        // access bank low/high split
    localparam logic [3:0]  ACCESS_HIGH_BANK      = 4'hF;         // sfr bank of access map
    localparam logic [11:0] ADDR_WREG             = 12'hFE8;      // working register address
    localparam logic [11:0] ADDR_PC_LOW           = 12'hFF9;      // program_counter_low_byte
    localparam logic [11:0] ADDR_STACK_TOP_LOW    = 12'hFFD;      // stack_top_low_byte
    localparam logic [11:0] ADDR_STACK_TOP_HIGH   = 12'hFFE;      // stack_top_high_byte
    localparam logic [11:0] ADDR_STACK_TOP_UPPER  = 12'hFFF;      // stack_top_upper_byte

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [7:0]  RESET_WREG            = 8'h00;        // working register at reset
    localparam logic [1:0]  RESET_PHASE           = 2'h0;         // starts in phase one

    // two-word move sequencer
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FF_SECOND
    } ff_state_t;

endpackage

/* tb/data_move_chk.sv */
`timescale 1ns/10ps
// ==========================================================
// port checker for the data move block
// ==========================================================
module data_move_chk
    import data_move_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // fetch path and core state
    input wire logic [15:0] instr,
    input wire logic        instr_valid,
    input wire logic        skip,
    input wire logic [3:0]  bank_selection_register,
    input wire logic [11:0] index_base,
    input wire logic        ext_set_en,
    // data memory and status
    input wire logic [11:0] mem_addr,
    input wire logic        mem_rd,
    input wire logic [7:0]  mem_rdata,
    input wire logic        mem_wr,
    input wire logic [7:0]  mem_wdata,
    input wire logic        flag_we,
    input wire logic        busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [1:0]  ph;     // mirror of the free running phase
    logic [15:0] lat;    // word taken in phase one
    logic        lat_ok; // word is real and not skipped
    logic [7:0]  cap;    // last value read from memory
    logic        move_file_to_dest;   // single-word move in this cycle
    // ==========================================================
    // helper state
    // ==========================================================
    // phase and latch restart with reset, like the design
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph     <= 2'h0;
            lat    <= 16'h0000;
            lat_ok <= 1'b0;
        end else begin
            ph <= ph + 2'h1;
            if (ph == 2'h0) begin
                lat    <= instr;
                lat_ok <= instr_valid && !skip;
            end
        end
    end
    // no reset: only looked at after a read
    always_ff @(posedge clk) begin
        if (mem_rd)
            cap <= mem_rdata;
    end
    assign move_file_to_dest = lat_ok && (lat[15:10] == OPC_MOVE_FILE_TO_DEST);
    // ==========================================================
    // assertions
    // ==========================================================
    a_access_bank: assert property (mem_rd && move_file_to_dest && !lat[8] && !(ext_set_en && lat[7:0] <= INDEXED_LIMIT)
        |-> mem_addr == ((lat[7:0] < ACCESS_SPLIT) ? {4'h0, lat[7:0]} : {ACCESS_HIGH_BANK, lat[7:0]}))
        else $error("access bank address wrong");
    a_bank_select: assert property (mem_rd && move_file_to_dest && lat[8] |-> mem_addr == {bank_selection_register, lat[7:0]})
        else $error("banked address wrong");
    a_indexed_offset: assert property (mem_rd && move_file_to_dest && !lat[8] && ext_set_en && lat[7:0] <= INDEXED_LIMIT
        |-> mem_addr == index_base + {4'h0, lat[7:0]}) else $error("indexed address wrong");
    a_ff_source: assert property (mem_rd && lat_ok && lat[15:12] == OPC_FF_FIRST |-> mem_addr == lat[11:0])
        else $error("source address wrong");
    a_ff_dest: assert property (busy && mem_wr |-> mem_addr == lat[11:0]) else $error("dest address wrong");
    a_busy_quiet: assert property (busy |-> !mem_rd && !flag_we) else $error("read or flags in second cycle");
    a_first_no_wr: assert property (lat_ok && lat[15:12] == OPC_FF_FIRST |-> !mem_wr) else $error("first word wrote");
    a_move_wb: assert property (mem_wr && move_file_to_dest |-> lat[POS_DEST_BIT] && mem_wdata == cap)
        else $error("write back wrong");
    a_wr_single: assert property (mem_wr |=> !mem_wr) else $error("write pulse too long");
    c_move_wb: cover property (mem_wr && move_file_to_dest);
    c_ff_write: cover property (busy && mem_wr);
    c_indexed: cover property (mem_rd && move_file_to_dest && ext_set_en && !lat[8]);
endmodule

bind data_move_instr_exec data_move_chk chk (.clk(clk), .rst_b(rst_b), .instr(instr), .instr_valid(instr_valid),
    .skip(skip), .bank_selection_register(bank_selection_register), .index_base(index_base),
    .ext_set_en(ext_set_en), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .flag_we(flag_we), .busy(busy));

/* tb/data_move_instr_exec_tb.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module data_move_instr_exec_tb;
    import data_move_pkg::*;
    // ==========================================================
    // stimulus and observation
    // ==========================================================
    logic        clk = 0, rst_b = 0, instr_valid = 1, skip = 0, ext_set_en = 0;
    logic [15:0] instr = 16'h0000;
    logic [3:0]  bank_selection_register = 4'h3;
    logic [11:0] index_base = 12'h100, mem_addr, wa;
    logic [7:0]  mem_rdata = 8'h00, mem_wdata, wreg, wd;
    logic        mem_rd, mem_wr, flag_n, flag_z, flag_we, busy, illegal_dest;
    int          err_count = 0, num_checks = 0, wr_n = 0, fl_n = 0, rd_n = 0, bz_n = 0, ill_n = 0;
    data_move_instr_exec uut (.clk(clk), .rst_b(rst_b), .instr(instr), .instr_valid(instr_valid), .skip(skip),
        .bank_selection_register(bank_selection_register), .index_base(index_base), .ext_set_en(ext_set_en),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .wreg(wreg), .flag_n(flag_n), .flag_z(flag_z), .flag_we(flag_we), .busy(busy), .illegal_dest(illegal_dest));
    always #10 clk = ~clk;
    // log writes and flag updates as they land; an unknown strobe counts as a pulse
    always @(posedge clk) begin
        if (mem_wr !== 1'b0) begin
            wr_n++;
            wa = mem_addr;
            wd = mem_wdata;
        end
        if (flag_we !== 1'b0)
            fl_n++;
        if (mem_rd !== 1'b0)
            rd_n++;
        if (busy !== 1'b0)
            bz_n++;
        if (illegal_dest !== 1'b0)
            ill_n++;
    end
    // ==========================================================
    // shared tasks
    // ==========================================================
    // one instruction slot: four clocks, word held throughout
    task slot(input logic [15:0] w, input logic sk);
        instr = w;
        skip  = sk;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // results land one edge late, so push a nop behind them
    task settle;
        instr_valid = 0;
        slot(16'h0000, 0);
        instr_valid = 1;
    endtask
    task test_done;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    // ==========================================================
    task t_move_file_to_dest_w;
        mem_rdata = 8'h80;
        wr_n = 0;
        slot(16'h5122, 0);
        settle;
        `CHK(wreg, 8'h80)
        `CHK({flag_n, flag_z}, 2'b10)
        `CHK(wr_n, 0)
    endtask
    task t_move_file_to_dest_wb;
        mem_rdata = 8'h00;
        fl_n = 0;
        slot(16'h5270, 0);
        settle;
        `CHK({wa, wd}, 20'hF70_00)
        `CHK({fl_n[0], flag_z}, 2'b11)
    endtask
    // offset 0x5F is still indexed, 0x60 falls back to the access bank
    task t_indexed;
        ext_set_en = 1;
        mem_rdata = 8'h5A;
        for (int i = 0; i < 2; i++) begin
            slot({8'h52, 8'h5F + 8'(i)}, 0);
            settle;
            `CHK(wa, (i == 0) ? index_base + 12'h05F : 12'hF60)
        end
        ext_set_en = 0;
    endtask
    task t_ff;
        mem_rdata = 8'h3C;
        wr_n = 0;
        fl_n = 0;
        rd_n = 0;
        bz_n = 0;
        ill_n = 0;
        slot(16'hC123, 0);
        slot(16'hF456, 0);
        settle;
        `CHK({wa, wd}, 20'h456_3C)
        `CHK({wr_n, fl_n}, {32'd1, 32'd0})
        `CHK({rd_n, bz_n}, {32'd1, 32'd4})
        `CHK(ill_n, 0)
    endtask
    task t_ff_w;
        mem_rdata = 8'h77;
        slot(16'h5122, 0);
        mem_rdata = 8'h00;
        slot(16'hCFE8, 0);
        slot(16'hF200, 0);
        settle;
        `CHK({wa, wd}, 20'h200_77)
        mem_rdata = 8'h11;
        slot(16'hC300, 0);
        slot(16'hFFE8, 0);
        settle;
        `CHK(wreg, 8'h11)
    endtask
    task t_illegal;
        logic [11:0] bad [4];
        bad = '{ADDR_PC_LOW, ADDR_STACK_TOP_LOW, ADDR_STACK_TOP_HIGH, ADDR_STACK_TOP_UPPER};
        foreach (bad[i]) begin
            wr_n = 0;
            ill_n = 0;
            slot(16'hC300, 0);
            slot({4'hF, bad[i]}, 0);
            settle;
            `CHK(wr_n, 0)
            `CHK(ill_n != 0, 1'b1)
        end
    endtask
    // skipped single move and skipped two-word move change nothing; the
    // unskipped 1111 word behind a skipped first word must run as a nop
    task t_skip;
        mem_rdata = 8'h99;
        wr_n = 0;
        slot(16'h5122, 1);
        slot(16'hC123, 1);
        slot(16'hF456, 0);
        settle;
        `CHK({wreg, wr_n}, {8'h11, 32'd0})
    endtask
    // ==========================================================
    // main sequence and watchdog
    // ==========================================================
    initial begin
        repeat (8) @(posedge clk);
        #1;
        rst_b = 1;
        t_move_file_to_dest_w;
        t_move_file_to_dest_wb;
        t_indexed;
        t_ff;
        t_ff_w;
        t_illegal;
        t_skip;
        test_done;
    end
    initial begin
        #(20 * 3000);
        err_count++;
        test_done;
    end
endmodule
